/* hdl/dims_device.sv */
/*
  device end: debounces power-up, latches the interface mode from the strap,
  qualifies connector selects and reset by mode, and drives the detect pins.
  assumes reset is the power-on reset; the ata hard/soft reset arrives on
  the link and never reaches the mode latch.
*/
`timescale 1ns/10ps
`include "dims_regs.svh"
module dims_device #(
  parameter int unsigned DEBOUNCE_CYC = `DIMS_DEBOUNCE_CYC,
  parameter bit HAS_DMA = 1'b0,
  parameter bit HAS_THROTTLE = 1'b0,
  parameter bit USE_CABLE_SEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  dims_link_if.device link,
  input wire logic dev_dma_req,
  input wire logic dev_not_ready,
  output dims_pkg::dims_mode_e mode,
  output logic cmd_select,
  output logic ctl_select,
  output logic dma_ack,
  output logic dev_reset,
  output logic is_device1
);
  import dims_pkg::*;

  // connector pins in synchroniser order
  localparam int NS = 7;
  localparam int IX_STRAP = 6;
  localparam int IX_CS_CMD = 5;
  localparam int IX_CS_CTL = 4;
  localparam int IX_DRV_SEL = 3;
  localparam int IX_CAB_SEL = 2;
  localparam int IX_RST = 1;
  localparam int IX_DACK = 0;
  // every connector input the device reads goes through two flops; defaults are negated levels,
  // so a half-mated connector can neither select nor reset the device
  localparam logic [NS-1:0] SYNC_RST = {NS{`DIMS_NEGATED_N}}; // R14
  wire [NS-1:0] raw_w;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;

  assign raw_w[IX_STRAP] = link.ata_mode_strap_n;
  assign raw_w[IX_CS_CMD] = link.chip_select_cmd_n;
  assign raw_w[IX_CS_CTL] = link.chip_select_ctl_n;
  assign raw_w[IX_DRV_SEL] = link.drive_select_n;
  assign raw_w[IX_CAB_SEL] = link.cable_select;
  assign raw_w[IX_RST] = link.bus_reset_line;
  assign raw_w[IX_DACK] = link.dma_acknowledge_n;

  // nothing but the second flop reads the first, so no logic ever sees
  // a metastable level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else if (clk_en) begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end

  wire strap_n_w = s2_q[IX_STRAP];
  wire cs_cmd_n_w = s2_q[IX_CS_CMD];
  // only the primary ctl select position is wired; the alternate is unused
  wire cs_ctl_n_w = s2_q[IX_CS_CTL]; // R8
  wire drv_sel_n_w = s2_q[IX_DRV_SEL];
  wire cab_sel_w = s2_q[IX_CAB_SEL];
  wire rst_line_w = s2_q[IX_RST];
  wire dack_n_w = s2_q[IX_DACK];

  // card-only inputs (upper address, write strobe) are deliberately unread,
  // so stray card-mode traffic never reaches the ata logic
  // R6

  logic [`DIMS_CNT_W-1:0] cnt_q;
  logic [`DIMS_CNT_W-1:0] cnt_d;
  dims_mode_e mode_q;
  dims_mode_e mode_d;
  wire done_w = (cnt_q >= `DIMS_CNT_W'(DEBOUNCE_CYC - 1));
  // the counter parks at its end value, so the window closes exactly once
  assign cnt_d = done_w ? cnt_q : cnt_q + `DIMS_CNT_W'(1); // R2

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      DIMS_MODE_WAIT: begin
        if (done_w) begin // R18
          mode_d = strap_n_w ? DIMS_MODE_CARD : DIMS_MODE_ATA; // R3
        end
      end
      DIMS_MODE_ATA: begin
        if (strap_n_w) begin
          mode_d = DIMS_MODE_OFF; // R5
        end
      end
      // card mode and disabled hold until the next power-on reset
      DIMS_MODE_CARD: begin
        mode_d = DIMS_MODE_CARD; // R4
      end
      DIMS_MODE_OFF: begin
        mode_d = DIMS_MODE_OFF; // R5
      end
      default: begin
        mode_d = DIMS_MODE_OFF;
      end
    endcase
  end

  // debounce window restarts only with power-on reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end

  // only power-on reset clears the mode; bus resets never touch it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= DIMS_MODE_WAIT;
    end else if (clk_en) begin
      mode_q <= mode_d;
    end
  end

  wire ata_w = (mode_q == DIMS_MODE_ATA);
  wire card_w = (mode_q == DIMS_MODE_CARD);
  // reset line is active low in ata mode and active high in card mode
  wire rst_act_w = ata_w ? !rst_line_w : (card_w ? rst_line_w : 1'b1); // R7

  // while waiting or disabled nothing is selected and reset is held
  wire cmd_d = ata_w && !cs_cmd_n_w; // R2
  wire ctl_d = ata_w && !cs_ctl_n_w; // R8
  wire dack_d = HAS_DMA && ata_w && !dack_n_w; // R11
  wire drst_d = rst_act_w; // R7
  // cable select is the default; the inverted drive select is the fallback
  wire dev1_sel_w = USE_CABLE_SEL ? cab_sel_w : !drv_sel_n_w; // R9
  wire dev1_d = ata_w && dev1_sel_w; // R2

  logic cmd_q;
  logic ctl_q;
  logic dack_q;
  logic drst_q;
  logic dev1_q;

  // one short flop per output keeps each reset value in plain sight
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_q <= 1'b0;
    end else if (clk_en) begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctl_q <= 1'b0;
    end else if (clk_en) begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dack_q <= 1'b0;
    end else if (clk_en) begin
      dack_q <= dack_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drst_q <= 1'b1;
    end else if (clk_en) begin
      drst_q <= drst_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dev1_q <= 1'b0;
    end else if (clk_en) begin
      dev1_q <= dev1_d;
    end
  end

  // registered outputs, straight from their flops
  assign mode = mode_q;
  assign cmd_select = cmd_q;
  assign ctl_select = ctl_q;
  assign dma_ack = dack_q;
  assign dev_reset = drst_q;
  assign is_device1 = dev1_q;

  // unimplemented optional outputs stay negated
  wire dreq_w = HAS_DMA && ata_w && dev_dma_req; // R11
  // throttle is high for ready, so an unsupported throttle stays high
  wire stall_w = HAS_THROTTLE && ata_w && dev_not_ready;
  assign link.dma_request = dreq_w; // R12
  assign link.ready_throttle = !stall_w; // R12
  // detect pins are tied low so the host sees the device straight away
  assign link.presence_detect_a_n = `DIMS_DETECT_RST; // R13
  assign link.presence_detect_b_n = `DIMS_DETECT_RST; // R13
endmodule

/* hdl/dims_regs.svh */
/*
  constants for the dual interface mode select front-end: debounce timing,
  counter width, input defaults and the reset values of the device's connector outputs.
  assumes a 20 MHz clk_sys on both ends; included by the package users.

// Behaviour
// R1: host asserts mode strap before power, always
// R2: device ignores inputs for 19 ms debounce
// R3: strap negated after debounce: card mode or silent
// R4: strap never resampled on hard or soft reset
// R5: strap lost in ata mode disables until power-off
// R6: ata mode ignores card-only connector inputs
// R7: reset polarity follows selected mode
// R8: host drives both ctl selects; device uses one
// R9: drive select inverts cable select; device uses one
// R10: host sets select levels before power
// R11: dma request and acknowledge come as a pair
// R12: unused throttle or dma request held negated
// R13: device grounds both detects; host sees presence
// R14: selects, reset, strap default negated internally
// R15: host resets all devices on insert or removal
// R16: host detects insertion or removal at an address
// R17: lock commands and change flags guard removal
// R18: debounce counter from power-on reset latches mode
*/
`ifndef DIMS_REGS_SVH
`define DIMS_REGS_SVH

`define DIMS_CLK_HZ 20000000
`define DIMS_DEBOUNCE_US 19000
`define DIMS_DEBOUNCE_CYC ((`DIMS_DEBOUNCE_US * (`DIMS_CLK_HZ / 1000000)))
`define DIMS_CNT_W 20
`define DIMS_DETECT_RST 1'b0
`define DIMS_NEGATED_N 1'b1

`endif

/* hdl/dims_pkg.sv */
/*
  types shared by both ends of the mode select link.
  assumes nothing beyond a SystemVerilog compiler.
*/
package dims_pkg;
  typedef enum logic [1:0] {
    DIMS_MODE_WAIT,
    DIMS_MODE_ATA,
    DIMS_MODE_CARD,
    DIMS_MODE_OFF
  } dims_mode_e;
endpackage

/* hdl/dims_link_if.sv */
/*
  connector-side signals between host controller and device front-end.
  assumes both ends run on one clk_sys; the bench supplies power sequencing.
*/
`timescale 1ns/10ps
interface dims_link_if;
  logic ata_mode_strap_n;
  logic chip_select_cmd_n;
  logic chip_select_ctl_n;
  logic chip_select_ctl_alt_n;
  logic drive_select_n;
  logic cable_select;
  logic bus_reset_line;
  logic dma_request;
  logic dma_acknowledge_n;
  logic ready_throttle;
  logic presence_detect_a_n;
  logic presence_detect_b_n;
  logic card_addr_hi;
  logic card_write_n;
  logic voltage_sense_a_n;
  logic voltage_sense_b_n;

  modport host (
    output ata_mode_strap_n, chip_select_cmd_n, chip_select_ctl_n,
    output chip_select_ctl_alt_n, drive_select_n, cable_select,
    output bus_reset_line, dma_acknowledge_n,
    input dma_request, ready_throttle, presence_detect_a_n,
    input presence_detect_b_n, voltage_sense_a_n, voltage_sense_b_n
  );
  modport device (
    input ata_mode_strap_n, chip_select_cmd_n, chip_select_ctl_n,
    input chip_select_ctl_alt_n, drive_select_n, cable_select,
    input bus_reset_line, dma_acknowledge_n, card_addr_hi, card_write_n,
    output dma_request, ready_throttle, presence_detect_a_n,
    output presence_detect_b_n
  );
endinterface

/* hdl/dims_host.sv */
/*
  host end: holds the mode strap asserted, duplicates the ctl select,
  drives cable select and its inverse, and reports device presence.
  assumes the strap and selects are valid from reset, before device power.
*/
`timescale 1ns/10ps
`include "dims_regs.svh"
module dims_host #(
  parameter bit HAS_DMA = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  dims_link_if.host link,
  input wire logic sel_cable,
  input wire logic req_cmd,
  input wire logic req_ctl,
  input wire logic req_bus_reset,
  input wire logic req_dma_ack,
  output logic present,
  output logic present_change,
  output logic dma_pending
);
  import dims_pkg::*;

  logic [1:0] det1_q;
  logic [1:0] det2_q;
  logic pres_q;
  logic chg_q;
  logic dreq1_q;
  logic dreq2_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      det1_q <= 2'h3;
      det2_q <= 2'h3;
      dreq1_q <= 1'b0;
      dreq2_q <= 1'b0;
      pres_q <= 1'b0;
      chg_q <= 1'b0;
    end else if (clk_en) begin
      det1_q <= {link.presence_detect_b_n, link.presence_detect_a_n};
      det2_q <= det1_q;
      dreq1_q <= link.dma_request;
      dreq2_q <= dreq1_q;
      pres_q <= (det2_q == 2'h0); // R13
      chg_q <= (pres_q != (det2_q == 2'h0)); // R16
    end
  end

  assign present = pres_q;
  // the host drives the bus reset line during this pulse; the user must reprogram the devices
  assign present_change = chg_q; // R15
  assign dma_pending = HAS_DMA && dreq2_q; // R11

  // strap and selects are combinational from reset, valid before power
  assign link.ata_mode_strap_n = 1'b0; // R1
  assign link.cable_select = sel_cable; // R10
  assign link.drive_select_n = !sel_cable; // R9
  assign link.chip_select_cmd_n = !(req_cmd && pres_q);
  assign link.chip_select_ctl_n = !(req_ctl && pres_q); // R8
  assign link.chip_select_ctl_alt_n = !(req_ctl && pres_q); // R8
  assign link.bus_reset_line = !(req_bus_reset || reset || chg_q); // R7 R15
  assign link.dma_acknowledge_n = !(HAS_DMA && req_dma_ack); // R11
  // R17: lock commands and change flags live in the command layer above
endmodule

/* test/dims_properties.sv */
/*
  link checker for the host and device ends of the mode select front-end.
  assumes both ends built without dma or throttle, one clk_sys domain.
*/
`timescale 1ns/10ps
module dims_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ata_mode_strap_n,
  input wire logic chip_select_ctl_n,
  input wire logic chip_select_ctl_alt_n,
  input wire logic drive_select_n,
  input wire logic cable_select,
  input wire logic dma_request,
  input wire logic dma_acknowledge_n,
  input wire logic ready_throttle,
  input wire logic presence_detect_a_n,
  input wire logic presence_detect_b_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_strap; ata_mode_strap_n == 1'b0; endproperty
  a_strap: assert property (p_strap) else $error("strap negated");
  property p_ctl_dup; chip_select_ctl_alt_n == chip_select_ctl_n; endproperty
  a_ctl_dup: assert property (p_ctl_dup) else $error("ctl differ");
  property p_ds_inv; drive_select_n == !cable_select; endproperty
  a_ds_inv: assert property (p_ds_inv) else $error("select not inv");
  property p_det_a; !presence_detect_a_n [*2]; endproperty
  a_det_a: assert property (p_det_a) else $error("detect a high");
  property p_det_b; presence_detect_b_n == presence_detect_a_n; endproperty
  a_det_b: assert property (p_det_b) else $error("detect b differs");
  property p_dma_request; !dma_request; endproperty
  a_dma_request: assert property (p_dma_request) else $error("dma request up");
  property p_rdy; ready_throttle ##1 ready_throttle; endproperty
  a_rdy: assert property (p_rdy) else $error("throttle low");
  property p_dma_acknowledge_n; dma_acknowledge_n && !dma_request; endproperty
  a_dma_acknowledge_n: assert property (p_dma_acknowledge_n) else $error("dma ack alone");
  c_cable: cover property ($rose(cable_select));
  c_ctl: cover property ($fell(chip_select_ctl_n));
  c_ds: cover property ($rose(drive_select_n));
endmodule

/* test/test_dual_interface_mode_select.sv */
/*
  bench: host and device back to back, plus a second device whose pins
  the bench drives to break host duties. assumes 20 MHz and short debounce.
*/
`timescale 1ns/10ps
module test_dual_interface_mode_select;
  import dims_pkg::*;
  localparam int DB = 20;
  logic clk_sys = 1'b0, reset = 1'b1, rst_b = 1'b1, en = 1'b1;
  logic [8:0] rv = 9'h006;
  logic bs = 1'b1, bc = 1'b1, br = 1'b1, cs, ls, ds, pr;
  logic pc, dp, da, d1;
  wire [2:0] bo;
  dims_mode_e md, mb;
  int err_total = 0, cmp_count = 0, cyc = 0;
  dims_link_if lk ();
  dims_link_if lkb ();
  always #25 clk_sys = ~clk_sys;
  assign lk.card_addr_hi = rv[7];
  assign lk.card_write_n = rv[8];
  assign lk.voltage_sense_a_n = rv[7];
  assign lk.voltage_sense_b_n = rv[8];
  assign lkb.ata_mode_strap_n = bs;
  assign lkb.chip_select_cmd_n = bc;
  assign lkb.bus_reset_line = br;
  assign lkb.chip_select_ctl_n = 1'b1;
  assign lkb.chip_select_ctl_alt_n = 1'b1;
  assign lkb.cable_select = 1'b0;
  assign lkb.drive_select_n = 1'b1;
  assign lkb.dma_acknowledge_n = 1'b1;
  assign lkb.card_addr_hi = rv[7];
  assign lkb.card_write_n = rv[8];
  assign lkb.voltage_sense_a_n = rv[7];
  assign lkb.voltage_sense_b_n = rv[8];
  dims_host u_dims_host (.clk_sys(clk_sys), .reset(reset), .clk_en(en),
    .link(lk.host), .sel_cable(rv[0]), .req_cmd(rv[1]), .req_ctl(rv[2]),
    .req_bus_reset(rv[3]), .req_dma_ack(rv[4]), .present(pr),
    .present_change(pc), .dma_pending(dp));
  dims_device #(.DEBOUNCE_CYC(DB)) u_dims_device (.clk_sys(clk_sys),
    .reset(reset), .clk_en(en), .link(lk.device), .dev_dma_req(rv[5]),
    .dev_not_ready(rv[6]), .mode(md), .cmd_select(cs), .ctl_select(ls),
    .dma_ack(da), .dev_reset(ds), .is_device1(d1));
  // second device: its connector is the bench, free to misbehave
  dims_device #(.DEBOUNCE_CYC(DB)) u_dims_device_b (.clk_sys(clk_sys),
    .reset(rst_b), .clk_en(en), .link(lkb.device), .dev_dma_req(rv[5]),
    .dev_not_ready(rv[6]), .mode(mb), .cmd_select(bo[2]),
    .ctl_select(bo[1]), .dma_ack(), .dev_reset(bo[0]), .is_device1());
  dims_properties u_dims_properties (.clk_sys(clk_sys), .reset(reset),
    .ata_mode_strap_n(lk.ata_mode_strap_n),
    .chip_select_ctl_n(lk.chip_select_ctl_n),
    .chip_select_ctl_alt_n(lk.chip_select_ctl_alt_n),
    .drive_select_n(lk.drive_select_n), .cable_select(lk.cable_select),
    .dma_request(lk.dma_request), .dma_acknowledge_n(lk.dma_acknowledge_n),
    .ready_throttle(lk.ready_throttle),
    .presence_detect_a_n(lk.presence_detect_a_n),
    .presence_detect_b_n(lk.presence_detect_b_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic dims_mode_e f_mode(input logic strap_n);
    return strap_n ? DIMS_MODE_CARD : DIMS_MODE_ATA;
  endfunction
  // ata reset line is low-active, so internal reset follows the request
  function automatic logic [2:0] f_sel(input logic [8:0] v);
    return {v[1], v[2], v[3]};
  endfunction
  // arguments are copied at the edge, before that edge's updates land,
  // so stimulus can go on being driven at the rising edge
  task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input dims_mode_e got, input dims_mode_e exp);
    chk_bits({1'b0, got}, {1'b0, exp});
  endtask
  task automatic finish_test();
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h8b85));
    tick(4);
    reset <= 1'b0;
    rst_b <= 1'b0;
    tick(4);
    chk_bits({pc, pr, 1'b0}, 3'h6);
    tick(2);
    chk_bits({cs, ls, ds}, 3'h1);
    chk_mode(md, DIMS_MODE_WAIT);
    tick(DB + 6);
    chk_mode(md, f_mode(1'b0));
    chk_mode(mb, f_mode(bs));
    for (int i = 0; i < 2; i++) begin
      br <= i[0];
      tick(5);
      chk_bits(bo, {2'b00, i[0]});
    end
    for (int i = 0; i < 60; i++) begin
      rv <= (i == 0) ? 9'h18E : 9'($urandom());
      tick(6);
      chk_bits({cs, ls, ds}, f_sel(rv));
      chk_bits({pr, pc, 1'b0}, 3'h4);
      chk_bits({d1, 2'b00}, {rv[0], 2'b00});
      chk_bits({da, dp, 1'b0}, 3'h0);
    end
    {bs, bc, br, rst_b} <= 4'h3;
    tick(4);
    rst_b <= 1'b0;
    tick(DB + 6);
    chk_mode(mb, f_mode(bs));
    chk_bits(bo, 3'h4);
    br <= 1'b0;
    tick(5);
    chk_bits(bo, 3'h5);
    chk_mode(mb, DIMS_MODE_ATA);
    {br, bs} <= 2'h3;
    tick(5);
    chk_mode(mb, DIMS_MODE_OFF);
    bs <= 1'b0;
    tick(5);
    chk_bits(bo, 3'h1);
    chk_mode(mb, DIMS_MODE_OFF);
    finish_test();
  end
endmodule
